// >>> bench/cgc_gain_regs_assertions.sv
// Concurrent checks on the ports of the codec gain register bank.
// Bound to every instance of the top module; one clock, async reset.
`timescale 1ns/1ps
module cgc_gain_regs_checker
   import cgc_pkg::*;
#(
   parameter int US_PER_MS = CGC_US_PER_MS,
   parameter int AGC_STEPS = CGC_AGC_STEPS
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [CGC_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [CGC_DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [CGC_DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic record_sample_strobe,
   input wire logic signed [7:0] record_level,
   input wire logic record_mute,
   input wire logic signed [7:0] record_gain_applied,
   input wire logic left_play_mute,
   input wire logic [CGC_VOL_W-1:0] left_play_volume,
   input wire logic right_play_mute,
   input wire logic [CGC_VOL_W-1:0] right_play_volume
);
   logic wr_rec;
   logic wr_pb;
   logic rd_rec;
   logic signed [7:0] sat_gain;
   logic agc_on;
   assign wr_rec = avs_write && !avs_waitrequest &&
      avs_address == CGC_ADDR_RECORD;
   assign wr_pb = avs_write && !avs_waitrequest &&
      avs_address == CGC_ADDR_PLAYBACK;
   assign rd_rec = avs_read && !avs_waitrequest &&
      avs_address == CGC_ADDR_RECORD;
   // Codes above 59.5 dB are clipped before they reach the gain stage.
   assign sat_gain = (avs_writedata[14:8] > 7'h77) ? 8'sh77 :
      {1'b0, avs_writedata[14:8]};

   // Shadow of the enable bit, rebuilt from the completed writes.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         agc_on <= 1'b0;
      else if (wr_rec && avs_byteenable[0])
         agc_on <= avs_writedata[0];
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_req_idle;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_one_wait;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   a_bus_one_wait: assert property (s_req_idle |=> s_one_wait)
      else $error("bus access not answered after one wait cycle");
   a_rec_mute_wr: assert property (
      wr_rec && avs_byteenable[1] |=>
      record_mute == $past(avs_writedata[15]))
      else $error("record mute does not follow the write");
   a_gain_prog: assert property (
      wr_rec && avs_byteenable[1:0] == 2'b11 && !avs_writedata[0] |=>
      ##1 record_gain_applied == $past(sat_gain, 2))
      else $error("programmed record gain wrong or not clipped");
   a_left_mute: assert property (
      wr_pb && avs_byteenable[1] |=>
      left_play_mute == $past(avs_writedata[15]))
      else $error("left mute does not follow the write");
   a_left_vol: assert property (
      wr_pb && avs_byteenable[1] |=>
      left_play_volume == $past(avs_writedata[14:8]))
      else $error("left volume does not follow the write");
   a_right_mute: assert property (
      wr_pb && avs_byteenable[0] |=>
      right_play_mute == $past(avs_writedata[7]))
      else $error("right mute does not follow the write");
   a_right_vol: assert property (
      wr_pb && avs_byteenable[0] |=>
      right_play_volume == $past(avs_writedata[6:0]))
      else $error("right volume does not follow the write");
   a_gain_range: assert property (
      record_gain_applied <= 8'sh77 && record_gain_applied >= 8'shE8)
      else $error("applied gain outside its range");
   a_gain_step: assert property (
      $changed(record_gain_applied) && $past(agc_on) &&
      $past(agc_on, 2) |->
      8'(record_gain_applied - $past(record_gain_applied))
      inside {8'h01, 8'hFF})
      else $error("automatic gain moved by more than one step");
   a_agc_read: assert property (
      rd_rec && avs_readdata[0] |->
      avs_readdata[15:8] == $past(record_gain_applied))
      else $error("readback does not show the applied gain");
endmodule

bind cgc_gain_regs cgc_gain_regs_checker #(
   .US_PER_MS(US_PER_MS),
   .AGC_STEPS(AGC_STEPS)
) u_checker (
   .clk(clk),
   .arst_n(arst_n),
   .avs_address(avs_address),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest),
   .record_sample_strobe(record_sample_strobe),
   .record_level(record_level),
   .record_mute(record_mute),
   .record_gain_applied(record_gain_applied),
   .left_play_mute(left_play_mute),
   .left_play_volume(left_play_volume),
   .right_play_mute(right_play_mute),
   .right_play_volume(right_play_volume)
);

// >>> bench/test_cgc_gain_regs.sv
// Self-checking bench for the codec gain register bank.
// Drives the Avalon-MM slave and the record sample path directly.
`timescale 1ns/1ps
module test_cgc_gain_regs
   import cgc_pkg::*;
;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [CGC_ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [CGC_DATA_W-1:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = '0;
   logic [CGC_DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   logic record_sample_strobe = 1'b0;
   logic signed [7:0] record_level = '0;
   logic record_mute;
   logic signed [7:0] record_gain_applied;
   logic left_play_mute;
   logic [CGC_VOL_W-1:0] left_play_volume;
   logic right_play_mute;
   logic [CGC_VOL_W-1:0] right_play_volume;
   int bad_count = 0;
   int n_checks = 0;
   int sp = 8;
   int scnt = 0;
   int gap;
   logic [15:0] rd;
   // Aimed output levels in half-dB units for target codes 0 to 7.
   int tgt[8] = '{-11, -16, -20, -24, -28, -34, -40, -48};
   int dms[4] = '{100, 200, 400, 500};
   logic [15:0] pv[4] = '{16'h0000, 16'h5A25, 16'h807F, 16'hFF80};
   logic [15:0] rv[4] = '{16'h0000, 16'hF7E6, 16'h781A, 16'hFF1E};

   // One millisecond is shrunk to one microsecond to keep the run short.
   cgc_gain_regs #(.US_PER_MS(1), .AGC_STEPS(16)) dut (
      .clk(clk),
      .arst_n(arst_n),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .record_sample_strobe(record_sample_strobe),
      .record_level(record_level),
      .record_mute(record_mute),
      .record_gain_applied(record_gain_applied),
      .left_play_mute(left_play_mute),
      .left_play_volume(left_play_volume),
      .right_play_mute(right_play_mute),
      .right_play_volume(right_play_volume)
   );

   initial
   begin
      forever #4 clk = ~clk;
   end

   always @(posedge clk)
   begin
      scnt <= (scnt + 1 >= sp) ? 0 : scnt + 1;
      record_sample_strobe <= (scnt == 0);
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // The request is held until waitrequest is seen low at a rising edge.
   task automatic bus(input logic wr, input logic [3:0] a,
      input logic [15:0] d);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {16'h0000, d};
      avs_byteenable <= 4'hF;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[15:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rchk(input logic [3:0] a, input logic [15:0] e);
      bus(1'b0, a, 16'h0000);
      check(rd, e);
   endtask

   // Clearing the enable first makes every call a fresh start.
   task automatic agc(input logic [6:0] g, input logic [2:0] t,
      input logic [3:0] c);
      bus(1'b1, CGC_ADDR_RECORD, 16'h0000);
      bus(1'b1, CGC_ADDR_RECORD, {1'b0, g, t, c, 1'b1});
      // The starting gain shows one cycle after the write has landed.
      @(posedge clk);
   endtask

   task automatic wait_step(input int lim);
      logic signed [7:0] g;
      g = record_gain_applied;
      gap = 0;
      do
      begin
         @(posedge clk);
         gap++;
      end
      while (record_gain_applied === g && gap < lim);
   endtask

   task automatic near(input int e, input int tol);
      check(16'(gap >= e - tol && gap <= e + tol), 16'h0001);
   endtask

   initial
   begin
      repeat (90000) @(posedge clk);
      bad_count++;
      finish_test();
   end

   initial
   begin
      repeat (8) @(posedge clk);
      check({13'h0000, record_mute, left_play_mute, right_play_mute},
         16'h0007);
      check({left_play_volume, 1'b0, right_play_volume, 1'b0},
         16'hFEFE);
      check({8'h00, record_gain_applied}, 16'h0000);
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rchk(CGC_ADDR_RECORD, 16'h8000);
      rchk(CGC_ADDR_PLAYBACK, 16'hFFFF);
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, CGC_ADDR_PLAYBACK, pv[i]);
         check({left_play_mute, left_play_volume, right_play_mute,
            right_play_volume}, pv[i]);
         rchk(CGC_ADDR_PLAYBACK, pv[i]);
      end
      // Strobes run with a loud level, which must not move the gain here.
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, CGC_ADDR_RECORD, rv[i]);
         repeat (200) @(posedge clk);
         check({7'h00, record_mute, record_gain_applied}, {7'h00, rv[i][15],
            (rv[i][14:8] > 7'h77) ? 8'h77 : {1'b0, rv[i][14:8]}});
         rchk(CGC_ADDR_RECORD, rv[i]);
      end
      bus(1'b1, 4'hC, 16'h1234);
      rchk(4'hC, 16'h0000);
      rchk(CGC_ADDR_PLAYBACK, 16'hFF80);
      rchk(CGC_ADDR_RECORD, rv[3]);
      record_level <= 8'sh00;
      for (int a = 0; a < 4; a++)
      begin
         sp = 5 + 30 * a;
         agc(7'h10, 3'd0, 4'(a));
         check({8'h00, record_gain_applied}, 16'h0010);
         wait_step(400);
         wait_step(400);
         near(125, sp + 2);
         check({8'h00, record_gain_applied}, 16'h000E);
      end
      sp = 8;
      record_level <= -8'sd60;
      for (int d = 0; d < 4; d++)
      begin
         agc(7'h10, 3'd0, 4'(d << 2));
         wait_step(5000);
         wait_step(5000);
         near((dms[d] / 16) * 125, 10);
         check({8'h00, record_gain_applied}, 16'h0012);
      end
      for (int t = 0; t < 8; t++)
      begin
         record_level <= 8'(tgt[t]);
         agc(7'h10, 3'(t), 4'h0);
         repeat (400) @(posedge clk);
         check({8'h00, record_gain_applied}, 16'h0010);
         record_level <= 8'(tgt[t] + 1);
         wait_step(400);
         check({8'h00, record_gain_applied}, 16'h000F);
      end
      record_level <= 8'sh00;
      agc(7'h00, 3'd0, 4'h0);
      repeat (3600) @(posedge clk);
      check({8'h00, record_gain_applied}, 16'h00E8);
      rchk(CGC_ADDR_RECORD, 16'hE801);
      record_level <= -8'sd60;
      agc(7'h7F, 3'd0, 4'h0);
      repeat (1700) @(posedge clk);
      check({8'h00, record_gain_applied}, 16'h0077);
      arst_n <= 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rchk(CGC_ADDR_RECORD, 16'h8000);
      rchk(CGC_ADDR_PLAYBACK, 16'hFFFF);
      finish_test();
   end
endmodule

// >>> design/cgc_gain_regs.sv
// Record and playback gain control registers with automatic gain control.
// Assumes an Avalon-MM master with byte addresses and a record path that
// gives one strobe per sample together with its measured output level.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
module cgc_gain_regs
   import cgc_pkg::*;
#(
   parameter int US_PER_MS = CGC_US_PER_MS,
   parameter int AGC_STEPS = CGC_AGC_STEPS
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [CGC_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [CGC_DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [CGC_DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic record_sample_strobe,
   input wire logic signed [7:0] record_level,
   output logic record_mute,
   output logic signed [7:0] record_gain_applied,
   output logic left_play_mute,
   output logic [CGC_VOL_W-1:0] left_play_volume,
   output logic right_play_mute,
   output logic [CGC_VOL_W-1:0] right_play_volume
);

   localparam int INTERVAL_W = 16;

   cgc_bus_state_e bus_state_reg;
   cgc_bus_state_e bus_state_next;
   cgc_agc_dir_e dir_reg;
   cgc_agc_dir_e dir_next;

   logic [CGC_GAIN_W-1:0] record_gain_reg;
   logic [CGC_TARGET_W-1:0] auto_gain_target_reg;
   logic [CGC_TC_W-1:0] auto_gain_time_constant_reg;
   logic auto_gain_enable_reg;

   logic request;
   logic accept;
   logic hit_record;
   logic hit_playback;
   logic [CGC_REG_W-1:0] record_word;
   logic [CGC_REG_W-1:0] playback_word;
   logic [CGC_REG_W-1:0] record_merged;
   logic [CGC_REG_W-1:0] playback_merged;
   logic [CGC_DATA_W-1:0] read_mux;

   logic [CGC_GAIN_W-1:0] pga_saturated;
   logic signed [7:0] target_level;
   logic [INTERVAL_W-1:0] attack_us;
   logic [INTERVAL_W-1:0] decay_us;
   logic [INTERVAL_W-1:0] interval_us;
   logic timer_clear;
   logic step_due;
   logic step_take;
   logic agc_started_reg;

   // Converts a time constant in milliseconds to microseconds per step.
   function automatic logic [INTERVAL_W-1:0] step_interval
   (
      input logic [15:0] ms
   );
      int us;
      us = (int'(ms) * US_PER_MS) / AGC_STEPS;
      if (us < 1)
      begin
         us = 1;
      end
      return INTERVAL_W'(us);
   endfunction

   // Bus access: one wait cycle, then the request completes.

   assign request = avs_read || avs_write;
   assign accept = request && (bus_state_reg == CGC_BUS_ACK);
   assign hit_record = (avs_address == CGC_ADDR_RECORD);
   assign hit_playback = (avs_address == CGC_ADDR_PLAYBACK);

   always_comb
   begin
      bus_state_next = bus_state_reg;
      case (bus_state_reg)
         CGC_BUS_IDLE:
         begin
            if (request)
            begin
               bus_state_next = CGC_BUS_ACK;
            end
         end
         CGC_BUS_ACK:
         begin
            bus_state_next = CGC_BUS_IDLE;
         end
         default:
         begin
            bus_state_next = CGC_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         bus_state_reg <= CGC_BUS_IDLE;
      else
         bus_state_reg <= bus_state_next;
   end

   // Waitrequest is registered, so it must already be low in the cycle
   // in which the master samples it; it rises again right after.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= (bus_state_next != CGC_BUS_ACK);
   end

   // Register words as software sees them.

   always_comb
   begin
      record_word = '0;
      record_word[CGC_REC_MUTE_BIT] = record_mute;
      record_word[CGC_REC_GAIN_LSB +: CGC_GAIN_W] = record_gain_reg;
      record_word[CGC_TARGET_LSB +: CGC_TARGET_W] = auto_gain_target_reg;
      record_word[CGC_TC_LSB +: CGC_TC_W] = auto_gain_time_constant_reg;
      record_word[CGC_AGC_EN_BIT] = auto_gain_enable_reg;
   end

   always_comb
   begin
      playback_word = '0;
      playback_word[CGC_LMUTE_BIT] = left_play_mute;
      playback_word[CGC_LVOL_LSB +: CGC_VOL_W] = left_play_volume;
      playback_word[CGC_RMUTE_BIT] = right_play_mute;
      playback_word[CGC_RVOL_LSB +: CGC_VOL_W] = right_play_volume;
   end

   // Byte enables select which of the two low lanes a write replaces.
   always_comb
   begin
      record_merged = record_word;
      playback_merged = playback_word;
      if (avs_byteenable[0])
      begin
         record_merged[7:0] = avs_writedata[7:0];
         playback_merged[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1])
      begin
         record_merged[15:8] = avs_writedata[15:8];
         playback_merged[15:8] = avs_writedata[15:8];
      end
   end

   // The top byte shows the applied gain while the controller runs and
   // the stored mute and gain otherwise; unmapped addresses read zero.
   always_comb
   begin
      read_mux = '0;
      if (hit_record)
      begin
         read_mux[CGC_REG_W-1:0] = record_word;
         if (auto_gain_enable_reg)
         begin
            read_mux[CGC_REG_W-1:CGC_REC_GAIN_LSB] =
               record_gain_applied;
         end
      end
      else if (hit_playback)
      begin
         read_mux[CGC_REG_W-1:0] = playback_word;
      end
   end

   // Read data is loaded as waitrequest falls and held until the next.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         avs_readdata <= '0;
      else if (avs_read && bus_state_next == CGC_BUS_ACK)
         avs_readdata <= read_mux;
   end

   // Record gain control fields.

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         record_mute <= CGC_RECORD_RESET[CGC_REC_MUTE_BIT];
         record_gain_reg <=
            CGC_RECORD_RESET[CGC_REC_GAIN_LSB +: CGC_GAIN_W];
         auto_gain_target_reg <=
            CGC_RECORD_RESET[CGC_TARGET_LSB +: CGC_TARGET_W];
         auto_gain_time_constant_reg <=
            CGC_RECORD_RESET[CGC_TC_LSB +: CGC_TC_W];
         auto_gain_enable_reg <= CGC_RECORD_RESET[CGC_AGC_EN_BIT];
      end
      else if (accept && avs_write && hit_record)
      begin
         record_mute <= record_merged[CGC_REC_MUTE_BIT];
         record_gain_reg <=
            record_merged[CGC_REC_GAIN_LSB +: CGC_GAIN_W];
         auto_gain_target_reg <=
            record_merged[CGC_TARGET_LSB +: CGC_TARGET_W];
         auto_gain_time_constant_reg <=
            record_merged[CGC_TC_LSB +: CGC_TC_W];
         auto_gain_enable_reg <= record_merged[CGC_AGC_EN_BIT];
      end
   end

   // Playback gain control fields.

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         left_play_mute <= CGC_PLAYBACK_RESET[CGC_LMUTE_BIT];
         left_play_volume <=
            CGC_PLAYBACK_RESET[CGC_LVOL_LSB +: CGC_VOL_W];
         right_play_mute <= CGC_PLAYBACK_RESET[CGC_RMUTE_BIT];
         right_play_volume <=
            CGC_PLAYBACK_RESET[CGC_RVOL_LSB +: CGC_VOL_W];
      end
      else if (accept && avs_write && hit_playback)
      begin
         left_play_mute <= playback_merged[CGC_LMUTE_BIT];
         left_play_volume <=
            playback_merged[CGC_LVOL_LSB +: CGC_VOL_W];
         right_play_mute <= playback_merged[CGC_RMUTE_BIT];
         right_play_volume <=
            playback_merged[CGC_RVOL_LSB +: CGC_VOL_W];
      end
   end

   // Automatic gain controller.

   // Codes above 59.5 dB are kept for readback but clamp in the stage.
   assign pga_saturated = (record_gain_reg > CGC_PGA_MAX) ?
      CGC_PGA_MAX : record_gain_reg;

   assign target_level = CGC_TARGET_TAB[auto_gain_target_reg];

   assign attack_us = step_interval(
      CGC_ATTACK_MS[auto_gain_time_constant_reg[CGC_ATTACK_W-1:0]]);
   assign decay_us = step_interval(
      CGC_DECAY_MS[auto_gain_time_constant_reg[CGC_TC_W-1:CGC_ATTACK_W]]);

   // A signal above target is attacked; below target the gain decays up.
   always_comb
   begin
      dir_next = CGC_AGC_HOLD;
      if (record_level > target_level)
      begin
         dir_next = CGC_AGC_ATTACK;
      end
      else if (record_level < target_level)
      begin
         dir_next = CGC_AGC_DECAY;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         dir_reg <= CGC_AGC_HOLD;
      else if (!auto_gain_enable_reg)
         dir_reg <= CGC_AGC_HOLD;
      else if (record_sample_strobe)
         dir_reg <= dir_next;
   end

   assign interval_us = (dir_reg == CGC_AGC_ATTACK) ?
      attack_us : decay_us;

   // Restarting on a change of direction keeps a partial decay interval
   // from being spent on an attack step.
   assign timer_clear = !auto_gain_enable_reg ||
      (dir_reg == CGC_AGC_HOLD) ||
      (record_sample_strobe && dir_next != dir_reg);

   // Step timing runs from the system clock and is only applied at the
   // next sample, so durations do not depend on the sample rate.
   assign step_take = step_due && record_sample_strobe;

   cgc_step_timer #(
      .CYCLES_PER_US(CGC_CYCLES_PER_US),
      .INTERVAL_W(INTERVAL_W)
   ) u_step_timer (
      .clk(clk),
      .arst_n(arst_n),
      .clear(timer_clear),
      .interval_us(interval_us),
      .consume(step_take),
      .step_due(step_due)
   );

   // The write that turns the controller on also carries its starting
   // gain, so the saturated programmed gain is loaded once more in the
   // first cycle after the enable has risen.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         agc_started_reg <= 1'b0;
      else
         agc_started_reg <= auto_gain_enable_reg;
   end

   // Applied record gain: follows the saturated programmed gain while the
   // controller is off, so enabling it starts from the programmed value.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         record_gain_applied <= '0;
      else if (!auto_gain_enable_reg || !agc_started_reg)
         record_gain_applied <= {1'b0, pga_saturated};
      else if (step_take)
      begin
         case (dir_reg)
            CGC_AGC_ATTACK:
            begin
               if (record_gain_applied > CGC_AGC_MIN)
                  record_gain_applied <= record_gain_applied - 8'sh01;
            end
            CGC_AGC_DECAY:
            begin
               if (record_gain_applied < CGC_AGC_MAX)
                  record_gain_applied <= record_gain_applied + 8'sh01;
            end
            default:
            begin
               record_gain_applied <= record_gain_applied;
            end
         endcase
      end
   end

endmodule

// >>> design/cgc_pkg.sv
// Constants shared by the codec gain control register bank.
// Assumes a 125 MHz system clock and word-aligned Avalon-MM accesses.
package cgc_pkg;

   localparam int CGC_ADDR_W = 4;
   localparam int CGC_DATA_W = 32;
   localparam int CGC_REG_W = 16;

   // Register indices; the byte address is four times the index.
   localparam logic [CGC_ADDR_W-1:0] CGC_IDX_RECORD = 4'h1;
   localparam logic [CGC_ADDR_W-1:0] CGC_IDX_PLAYBACK = 4'h2;
   localparam logic [CGC_ADDR_W-1:0] CGC_ADDR_RECORD =
      CGC_ADDR_W'(CGC_IDX_RECORD * 4);
   localparam logic [CGC_ADDR_W-1:0] CGC_ADDR_PLAYBACK =
      CGC_ADDR_W'(CGC_IDX_PLAYBACK * 4);

   // Record gain control fields.
   localparam int CGC_REC_MUTE_BIT = 15;
   localparam int CGC_REC_GAIN_LSB = 8;
   localparam int CGC_GAIN_W = 7;
   localparam int CGC_TARGET_LSB = 5;
   localparam int CGC_TARGET_W = 3;
   localparam int CGC_TC_LSB = 1;
   localparam int CGC_TC_W = 4;
   localparam int CGC_ATTACK_W = 2;
   localparam int CGC_AGC_EN_BIT = 0;

   // Playback gain control fields.
   localparam int CGC_LMUTE_BIT = 15;
   localparam int CGC_LVOL_LSB = 8;
   localparam int CGC_RMUTE_BIT = 7;
   localparam int CGC_RVOL_LSB = 0;
   localparam int CGC_VOL_W = 7;

   // Reset values.
   localparam logic [CGC_REG_W-1:0] CGC_RECORD_RESET = 16'h8000;
   localparam logic [CGC_REG_W-1:0] CGC_PLAYBACK_RESET = 16'hFFFF;

   // Gains in signed half-dB units.
   localparam logic [CGC_GAIN_W-1:0] CGC_PGA_MAX = 7'h77;
   localparam logic signed [7:0] CGC_AGC_MAX = 8'sh77;
   localparam logic signed [7:0] CGC_AGC_MIN = 8'shE8;

   // Target output levels in half-dB units: -5.5 dB down to -24 dB.
   localparam logic signed [7:0] CGC_TARGET_TAB [8] = '{
      8'shF5, 8'shF0, 8'shEC, 8'shE8, 8'shE4, 8'shDE, 8'shD8, 8'shD0};

   // Attack and decay times in milliseconds.
   localparam logic [15:0] CGC_ATTACK_MS [4] = '{
      16'h0008, 16'h000B, 16'h0010, 16'h0014};
   localparam logic [15:0] CGC_DECAY_MS [4] = '{
      16'h0064, 16'h00C8, 16'h0190, 16'h01F4};

   // Clock period in ns, microsecond in ns and derived cycle count.
   localparam int CGC_CLK_PERIOD_NS = 8;
   localparam int CGC_NS_PER_US = 1000;
   localparam int CGC_CYCLES_PER_US = CGC_NS_PER_US / CGC_CLK_PERIOD_NS;
   localparam int CGC_US_PER_MS = 1000;

   // Half-dB steps spread over one time constant.
   localparam int CGC_AGC_STEPS = 16;

   typedef enum logic {CGC_BUS_IDLE, CGC_BUS_ACK} cgc_bus_state_e;
   typedef enum logic [1:0]
      {CGC_AGC_HOLD, CGC_AGC_ATTACK, CGC_AGC_DECAY} cgc_agc_dir_e;

endpackage

// >>> design/cgc_step_timer.sv
// Step timer for the automatic gain controller.
// Counts microseconds from the system clock and raises a pending flag
// each time the programmed interval has elapsed.
`timescale 1ns/1ps
module cgc_step_timer
   import cgc_pkg::*;
#(
   parameter int CYCLES_PER_US = CGC_CYCLES_PER_US,
   parameter int INTERVAL_W = 16
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clear,
   input wire logic [INTERVAL_W-1:0] interval_us,
   input wire logic consume,
   output logic step_due
);

   localparam int PRE_W = $clog2(CYCLES_PER_US + 1);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYCLES_PER_US - 1);

   logic [PRE_W-1:0] pre_reg;
   logic [INTERVAL_W-1:0] us_reg;
   logic us_tick;
   logic interval_done;

   assign us_tick = (pre_reg == PRE_LAST);
   assign interval_done = us_tick && (us_reg + 1'b1 >= interval_us);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         pre_reg <= '0;
      else if (clear || us_tick)
         pre_reg <= '0;
      else
         pre_reg <= pre_reg + 1'b1;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         us_reg <= '0;
      else if (clear || interval_done)
         us_reg <= '0;
      else if (us_tick)
         us_reg <= us_reg + 1'b1;
   end

   // An interval that ends in the cycle the flag is consumed wins.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         step_due <= 1'b0;
      else if (clear)
         step_due <= 1'b0;
      else if (interval_done)
         step_due <= 1'b1;
      else if (consume)
         step_due <= 1'b0;
   end

endmodule
